// ==== design/scs_card.sv ====
// Card-side session controller: states, ATR sender, character rate, SLEEP reply
// How it works
// - Runs purely from the supplied card clock, no internal timing source.
// - Characteristics byte 1 bit 2 set when fast clock is needed.
// - Operating while executing a command, idle otherwise, data retained.
// - SLEEP from an old equipment gets normal completion status words.
// - Answer to reset runs at clock divided by 372.
// - Rate stays at clock/372 until a negotiation succeeds.
// - Session starts with an answer to reset of at most 33 characters.
// - TS goes first and sets the bit convention of later characters.
// - T0 always follows TS, announcing interface and historical characters.
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
module scs_card
  import scs_pkg::*;
#(
  parameter int unsigned ATR_DEPTH = ATR_MAX_CHARS
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Card clock and reset from the equipment, synchronous samples
  input wire logic card_clk_i,
  input wire logic card_rst_n_i,
  // Serial line, open drain
  input wire logic io_i,
  output logic io_o,
  output logic io_oe_o,
  // Software register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Session status
  output logic operating_o,
  output logic clk_stop_ok_o
);
  initial begin
    if (ATR_DEPTH > ATR_MAX_CHARS || ATR_DEPTH < 2) $error("scs_card: bad ATR_DEPTH");
  end

  // Register and session state
  scs_state_t st_q, st_d;
  logic [7:0] char_q, char_d;
  logic [5:0] atr_len_q, atr_len_d;
  logic [5:0] atr_idx_q, atr_idx_d;
  logic inverse_q, inverse_d;
  logic [15:0] div_q, div_d;
  logic busy_q, busy_d;
  logic sleep_q, sleep_d;
  logic [7:0] hrd_q, hrd_d;
  logic hrd_new_q, hrd_new_d;
  logic [15:0] rdata_q, rdata_d;
  // Transmit character engine
  logic [15:0] etu_cnt_q, etu_cnt_d;
  logic [3:0] bit_q, bit_d;
  logic [9:0] sh_q, sh_d;
  logic tx_act_q, tx_act_d;
  logic [7:0] tx_fifo_q, tx_fifo_d;
  logic tx_pend_q, tx_pend_d;
  logic [1:0] sw_cnt_q, sw_cnt_d;
  logic clk_q, rise;
  logic [7:0] rom_rdata;
  logic rom_we;
  logic [7:0] tx_byte;

  assign rise = card_clk_i & ~clk_q;
  assign rom_we = wr_i && addr_i == REG_HIST && st_q == SCS_OFF;

  scs_atr_rom #(.DEPTH(ATR_DEPTH)) u_rom (
    .mclk_i(mclk_i),
    .we_i(rom_we),
    .waddr_i(wdata_i[13:8]),
    .wdata_i(wdata_i[7:0]),
    .raddr_i(atr_idx_q),
    .rdata_o(rom_rdata)
  );

  // Inverse convention complements and reverses data bits
  function automatic logic [7:0] code_byte(input logic [7:0] b, input logic inv);
    logic [7:0] r;
    r = b;
    if (inv) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = ~b[7 - i];
      end
    end
    return r;
  endfunction

  always_comb begin
    st_d = st_q;
    char_d = char_q;
    atr_len_d = atr_len_q;
    atr_idx_d = atr_idx_q;
    inverse_d = inverse_q;
    div_d = div_q;
    busy_d = busy_q;
    sleep_d = sleep_q;
    hrd_d = hrd_q;
    hrd_new_d = hrd_new_q;
    rdata_d = 16'h0000;
    etu_cnt_d = etu_cnt_q;
    bit_d = bit_q;
    sh_d = sh_q;
    tx_act_d = tx_act_q;
    tx_fifo_d = tx_fifo_q;
    tx_pend_d = tx_pend_q;
    sw_cnt_d = sw_cnt_q;
    tx_byte = 8'h00;
    // Software writes
    if (wr_i) begin
      unique case (addr_i)
        REG_CTRL: begin
          busy_d = wdata_i[0];
          sleep_d = wdata_i[1];
        end
        // Fast clock and stop permission bits
        REG_CHAR: char_d = wdata_i[7:0];
        // Length kept from two up to the store depth
        REG_HIST: atr_len_d = (st_q != SCS_OFF || wdata_i[13:8] - 6'h01 >= 6'(ATR_DEPTH - 1))
          ? atr_len_q : wdata_i[13:8] + 6'h01;
        // Rate changes only once software reports a negotiation
        REG_DIV: div_d = (st_q == SCS_IDLE && wdata_i != 16'h0000) ? wdata_i : div_q;
        REG_HWR: begin
          if (!tx_pend_q) begin
            tx_fifo_d = wdata_i[7:0];
            tx_pend_d = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        REG_CTRL: rdata_d = {14'h0000, sleep_q, busy_q};
        REG_STAT: rdata_d = {9'h000, tx_pend_q, hrd_new_q, inverse_q, tx_act_q, clk_stop_ok_o,
                             st_q};
        REG_CHAR: rdata_d = {8'h00, char_q};
        REG_DIV: rdata_d = div_q;
        REG_HRD: rdata_d = {8'h00, hrd_q};
        default: rdata_d = 16'h0000;
      endcase
      hrd_new_d = hrd_new_q && addr_i != REG_HRD;
    end
    // Bit timing counted in card clock rising edges
    if (tx_act_q && rise) begin
      if (etu_cnt_q == div_q - 16'h0001) begin
        etu_cnt_d = 16'h0000;
        if (bit_q == 4'd11) begin
          tx_act_d = 1'b0;
        end else begin
          bit_d = bit_q + 4'd1;
          if (bit_q < 4'd9) begin
            sh_d = {1'b1, sh_q[9:1]};
          end
        end
      end else begin
        etu_cnt_d = etu_cnt_q + 16'h0001;
      end
    end
    // Session state machine
    unique case (st_q)
      SCS_OFF: begin
        if (card_rst_n_i) begin
          st_d = SCS_ATR;
          atr_idx_d = 6'h00;
        end
      end
      SCS_ATR: begin
        // Send stored characters, TS then T0 first
        if (!tx_act_q && !tx_act_d) begin
          if (atr_idx_q >= atr_len_q) begin
            st_d = SCS_IDLE;
          end else if (rise) begin
            tx_byte = rom_rdata;
            // TS sent raw and latched as the convention
            if (atr_idx_q == 6'h00) begin
              inverse_d = (rom_rdata == TS_INVERSE);
            end else begin
              tx_byte = code_byte(rom_rdata, inverse_q);
            end
            sh_d = {^tx_byte, tx_byte, 1'b0};
            tx_act_d = 1'b1;
            bit_d = 4'd0;
            etu_cnt_d = 16'h0000;
            atr_idx_d = atr_idx_q + 6'h01;
          end
        end
      end
      SCS_IDLE: begin
        // Any command activity moves to operating
        if (busy_q || sleep_q || tx_pend_q || !io_i) begin
          st_d = SCS_OPER;
        end
      end
      SCS_OPER: begin
        // SLEEP answered with normal completion words
        if (sleep_q && !tx_act_q && sw_cnt_q < 2'd2 && rise) begin
          tx_byte = code_byte(sw_cnt_q == 2'd0 ? SW1_OK : SW2_OK, inverse_q);
          sh_d = {^tx_byte, tx_byte, 1'b0};
          tx_act_d = 1'b1;
          bit_d = 4'd0;
          etu_cnt_d = 16'h0000;
          sw_cnt_d = sw_cnt_q + 2'd1;
        end else if (sleep_q && sw_cnt_q == 2'd2 && !tx_act_q) begin
          sleep_d = wr_i && addr_i == REG_CTRL && wdata_i[1];
          sw_cnt_d = 2'd0;
        end else if (tx_pend_q && !tx_act_q && rise) begin
          tx_byte = code_byte(tx_fifo_q, inverse_q);
          sh_d = {^tx_byte, tx_byte, 1'b0};
          tx_act_d = 1'b1;
          bit_d = 4'd0;
          etu_cnt_d = 16'h0000;
          tx_pend_d = 1'b0;
        end else if (!busy_q && !sleep_q && !tx_pend_q && !tx_act_q) begin
          st_d = SCS_IDLE;
        end
      end
    endcase
    // Last received byte from software mailbox sets flag; set beats clear
    if (wr_i && addr_i == REG_HWR) begin
      hrd_d = wdata_i[15:8];
      hrd_new_d = 1'b1;
    end
    // Card reset restores the answer-to-reset rate and restarts the string
    if (!card_rst_n_i) begin
      st_d = SCS_OFF;
      atr_idx_d = 6'h00;
      div_d = ETU_DIV_RESET;
      tx_act_d = 1'b0;
      tx_pend_d = 1'b0;
      sleep_d = 1'b0;
      sw_cnt_d = 2'd0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= SCS_OFF;
      char_q <= 8'h00;
      atr_len_q <= 6'h02;
      atr_idx_q <= 6'h00;
      inverse_q <= 1'b0;
      div_q <= ETU_DIV_RESET;
      busy_q <= 1'b0;
      sleep_q <= 1'b0;
      hrd_q <= 8'h00;
      hrd_new_q <= 1'b0;
      rdata_q <= 16'h0000;
      etu_cnt_q <= 16'h0000;
      bit_q <= 4'd0;
      sh_q <= 10'h3FF;
      tx_act_q <= 1'b0;
      tx_fifo_q <= 8'h00;
      tx_pend_q <= 1'b0;
      sw_cnt_q <= 2'd0;
      clk_q <= 1'b0;
    end else begin
      st_q <= st_d;
      char_q <= char_d;
      atr_len_q <= atr_len_d;
      atr_idx_q <= atr_idx_d;
      inverse_q <= inverse_d;
      div_q <= div_d;
      busy_q <= busy_d;
      sleep_q <= sleep_d;
      hrd_q <= hrd_d;
      hrd_new_q <= hrd_new_d;
      rdata_q <= rdata_d;
      etu_cnt_q <= etu_cnt_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      tx_act_q <= tx_act_d;
      tx_fifo_q <= tx_fifo_d;
      tx_pend_q <= tx_pend_d;
      sw_cnt_q <= sw_cnt_d;
      clk_q <= card_clk_i;
    end
  end

  // Open drain: drive only a low, guard bits release the line
  assign io_o = 1'b0;
  assign io_oe_o = tx_act_q && bit_q < 4'd10 && !sh_q[0];
  assign rdata_o = rdata_q;
  assign operating_o = (st_q == SCS_OPER);
  // Clock stop allowed only when idle and permitted
  assign clk_stop_ok_o = (st_q == SCS_IDLE) && char_q[CHR_STOP_BIT];
endmodule

// ==== design/scs_pkg.sv ====
// Shared constants for the card session controller
package scs_pkg;
  // Clock and rate
  localparam int unsigned MCLK_HZ = 25000000;
  localparam int unsigned ETU_DIV_DEF = 372;
  localparam logic [15:0] ETU_DIV_RESET = 16'h0174;
  localparam int unsigned GUARD_ETU = 2;
  // Answer to reset
  localparam int unsigned ATR_MAX_CHARS = 33;
  localparam logic [7:0] TS_DIRECT = 8'h3B;
  localparam logic [7:0] TS_INVERSE = 8'h3F;
  localparam logic [7:0] TA1_DEFAULT = 8'h11;
  localparam logic [7:0] TB1_NO_VPP = 8'h00;
  // Normal completion status words
  localparam logic [7:0] SW1_OK = 8'h90;
  localparam logic [7:0] SW2_OK = 8'h00;
  // Characteristics byte 1, clock-stop and frequency bits
  localparam int unsigned CHR_FAST_BIT = 1;
  localparam int unsigned CHR_STOP_BIT = 0;
  // Register offsets of the plain software port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_CHAR = 4'h2;
  localparam logic [3:0] REG_HIST = 4'h3;
  localparam logic [3:0] REG_DIV = 4'h4;
  localparam logic [3:0] REG_HWR = 4'h5;
  localparam logic [3:0] REG_HRD = 4'h6;
  typedef enum logic [1:0] {SCS_OFF, SCS_ATR, SCS_IDLE, SCS_OPER} scs_state_t;
endpackage

// ==== design/scs_atr_rom.sv ====
// Small memory holding the answer-to-reset character string
`timescale 1ns/1ps
module scs_atr_rom
  import scs_pkg::*;
#(
  parameter int unsigned DEPTH = ATR_MAX_CHARS
) (
  // Clock
  input wire logic mclk_i,
  // Write port
  input wire logic we_i,
  input wire logic [5:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // Read port
  input wire logic [5:0] raddr_i,
  output logic [7:0] rdata_o
);
  initial begin
    if (DEPTH > 63 || DEPTH < 2) $error("scs_atr_rom: DEPTH out of range");
  end
  logic [7:0] mem_q [DEPTH];
  logic [7:0] rdata_q;
  always_ff @(posedge mclk_i) begin
    if (we_i && waddr_i < 6'(DEPTH)) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_q <= (raddr_i < 6'(DEPTH)) ? mem_q[raddr_i] : 8'h00;
  end
  assign rdata_o = rdata_q;
endmodule

// ==== verification/scs_card_properties.sv ====
// Port checks for the card session controller
`timescale 1ns/1ps
module scs_card_properties
  import scs_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Card side
  input wire logic card_clk_i,
  input wire logic card_rst_n_i,
  input wire logic io_o,
  input wire logic io_oe_o,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  // Status
  input wire logic operating_o,
  input wire logic clk_stop_ok_o
);
  logic ck_q, ck_d, oe_q, oe_d;
  logic [15:0] div_q, div_d, cnt_q, cnt_d;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Card clock rises since the line was last pulled low
  always_comb begin
    ck_d = card_clk_i;
    oe_d = io_oe_o;
    div_d = div_q;
    cnt_d = (io_oe_o && !oe_q) ? 16'h0000 : cnt_q + {15'h0000, card_clk_i && !ck_q};
    if (!card_rst_n_i) begin
      div_d = ETU_DIV_RESET;
    end else if (wr_i && addr_i == REG_DIV && !operating_o && wdata_i != 16'h0000) begin
      div_d = wdata_i;
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ck_q <= 1'b0;
      oe_q <= 1'b0;
      div_q <= ETU_DIV_RESET;
      cnt_q <= 16'h0000;
    end else begin
      ck_q <= ck_d;
      oe_q <= oe_d;
      div_q <= div_d;
      cnt_q <= cnt_d;
    end
  end
  sequence sleep_req;
    wr_i && addr_i == REG_CTRL && wdata_i[1] && clk_stop_ok_o && card_rst_n_i;
  endsequence
  sequence bit_held;
    io_oe_o [*8];
  endsequence
  drive_low_a: assert property (io_oe_o |-> io_o == 1'b0)
    else $error("line driven high");
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data without read");
  div_read_a: assert property (rd_i && addr_i == REG_DIV |=> rdata_o == div_q)
    else $error("divider readback wrong");
  off_quiet_a: assert property (!card_rst_n_i [*2] |-> !io_oe_o && !operating_o)
    else $error("activity while card held in reset");
  stop_idle_a: assert property (clk_stop_ok_o |-> !operating_o)
    else $error("clock stop offered while operating");
  stop_char_a: assert property (wr_i && addr_i == REG_CHAR && !wdata_i[CHR_STOP_BIT]
    |=> !clk_stop_ok_o)
    else $error("clock stop offered though not allowed");
  etu_span_a: assert property ($fell(io_oe_o) |-> cnt_q != 0 && cnt_q % div_q == 0)
    else $error("low span not whole bits");
  sleep_reply_a: assert property (sleep_req |-> ##[1:100] io_oe_o)
    else $error("no reply to sleep");
  bit_hold_a: assert property ($rose(io_oe_o) |-> bit_held)
    else $error("bit glitch on line");
endmodule

// ==== verification/scs_equip_model.sv ====
// Equipment model: card clock, pulled-up line and character receiver
`timescale 1ns/1ps
module scs_equip_model (
  // Clock
  input wire logic mclk_i,
  // Card side
  input wire logic io_oe_i,
  output logic card_clk_o,
  output logic io_line_o,
  // Bench side
  input wire logic clk_run_i,
  input wire logic [15:0] etu_i,
  output logic [8:0] rx_o,
  output logic rx_stb_o
);
  logic [2:0] ph = 3'h2;
  // High 2 of 5 periods; a stop always lands on the low phase
  always @(posedge mclk_i) begin
    if (clk_run_i || ph != 3'h2) begin
      ph <= (ph == 3'h4) ? 3'h0 : ph + 3'h1;
    end
  end
  assign card_clk_o = ph < 3'h2;
  assign io_line_o = (io_oe_i === 1'b1) ? 1'b0 : 1'b1;
  task automatic wait_rises(input int n);
    repeat (n) @(posedge card_clk_o);
  endtask
  // Mid-bit sampling of 8 data LSB first and parity, timed from the start bit
  initial begin
    rx_stb_o = 1'b0;
    rx_o = 9'h000;
    forever begin
      @(negedge io_line_o);
      wait_rises(etu_i / 2);
      for (int i = 0; i < 9; i++) begin
        wait_rises(etu_i);
        rx_o[i] = io_line_o;
      end
      rx_stb_o = 1'b1;
      wait_rises(etu_i);
      rx_stb_o = 1'b0;
    end
  end
endmodule

// ==== verification/smart_card_session_ctrl_test.sv ====
// Top testbench of the card session controller
`timescale 1ns/1ps
bind scs_card scs_card_properties u_props (.mclk_i(mclk_i), .rst_i(rst_i),
  .card_clk_i(card_clk_i), .card_rst_n_i(card_rst_n_i), .io_o(io_o), .io_oe_o(io_oe_o),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .operating_o(operating_o), .clk_stop_ok_o(clk_stop_ok_o));
module smart_card_session_ctrl_test;
  import scs_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic card_rst_n = 1'b0;
  logic clk_run = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] etu = 16'h0174;
  logic [15:0] rdata;
  logic card_clk, io_line, io_o, io_oe, operating, stop_ok, rx_stb;
  logic [8:0] rx;
  logic [15:0] chr;
  int n_fail = 0;
  int num_checks = 0;
  int seed = 32'hcd4e;
  int rx_cnt = 0;
  logic [7:0] exp_q[$];
  scs_card DUT (.mclk_i(mclk_i), .rst_i(rst_i), .card_clk_i(card_clk),
    .card_rst_n_i(card_rst_n), .io_i(io_line), .io_o(io_o), .io_oe_o(io_oe), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .operating_o(operating),
    .clk_stop_ok_o(stop_ok));
  scs_equip_model u_equip (.mclk_i(mclk_i), .io_oe_i(io_oe), .card_clk_o(card_clk),
    .io_line_o(io_line), .clk_run_i(clk_run), .etu_i(etu), .rx_o(rx), .rx_stb_o(rx_stb));
  initial forever #20 mclk_i = ~mclk_i;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
    @(posedge mclk_i);
    // Step past the edge so callers see the registered effect of the write
    #1;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1;
    check(rdata, e);
    @(posedge mclk_i);
  endtask
  task automatic wait_rx(input int n);
    for (int k = 0; k < 100000 && rx_cnt < n; k++) begin
      @(posedge mclk_i);
    end
    check(16'(rx_cnt), 16'(n));
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Characters arrive in the queued order with even parity
  always @(posedge rx_stb) begin
    rx_cnt++;
    check({7'h00, rx}, {7'h00, ^exp_q[0], exp_q[0]});
    void'(exp_q.pop_front());
  end
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    rd_chk(REG_DIV, ETU_DIV_RESET);
    // T0 announces only TA1, which asks for a faster rate
    exp_q = '{TS_DIRECT, 8'h10, 8'h13};
    foreach (exp_q[i]) begin
      wr_reg(REG_HIST, {2'b00, 6'(i), exp_q[i]});
    end
    clk_run <= 1'b1;
    repeat (10) @(posedge mclk_i);
    card_rst_n <= 1'b1;
    wait_rx(3);
    // Parity was sampled mid-bit; let the guard time end so the card is idle
    repeat (3 * ETU_DIV_DEF) @(posedge card_clk);
    $display("Answer to reset test done");
    chr = {8'h00, 7'($random(seed)), 1'b1};
    wr_reg(REG_CHAR, chr);
    rd_chk(REG_CHAR, chr);
    check({14'h0000, operating, stop_ok}, 16'h0001);
    wr_reg(REG_DIV, 16'h005D);
    wr_reg(4'hF, 16'h0174);
    rd_chk(REG_DIV, 16'h005D);
    etu = 16'h005D;
    exp_q = '{SW1_OK, SW2_OK};
    // Only a first-phase equipment sends SLEEP, the role played here
    wr_reg(REG_CTRL, 16'h0002);
    wait_rx(5);
    $display("Sleep test done");
    // Stop wait counted in card clocks covers both equipment phases
    repeat (1860) @(posedge card_clk);
    check({15'h0000, stop_ok}, 16'h0001);
    clk_run <= 1'b0;
    repeat (300) @(posedge mclk_i);
    clk_run <= 1'b1;
    // Restarted clock runs 744 card clocks before the next command
    repeat (744) @(posedge card_clk);
    @(posedge mclk_i);
    wr_reg(REG_CTRL, 16'h0001);
    check({15'h0000, operating}, 16'h0001);
    wr_reg(REG_CTRL, 16'h0000);
    check({15'h0000, operating}, 16'h0000);
    wr_reg(REG_CHAR, 16'h0000);
    check({15'h0000, stop_ok}, 16'h0000);
    $display("Clock stop test done");
    give_verdict();
  end
  initial begin
    // The scenarios need about 92000 cycles, mostly the slow answer to reset
    repeat (98000) @(posedge mclk_i);
    n_fail++;
    give_verdict();
  end
endmodule
